/* File: rtl/mmvd_memory_map.sv */
// Upper memory map decoder: RAM, ROM, vectors, stack sequencing, watchdog location.
// Assumes the CPU core drives the bus and stack requests on CORE_CLK.
// What this block does
// - Reads at the top location give reset vector low; writes clear watchdog.
// - Vector slots run from lowest slot to top, high then low, top wins.
// - Undefined ROM bytes, unused vectors included, read as the trap opcode.
// - Decode 2048 RAM bytes in two regions, 176 of them in page zero.
// - Stack pointer is 16 bits wide; software keeps it inside RAM.
// - Stack pointer resets to top of page-zero RAM; reload restores it.
// - Interrupt entry pushes five context bytes before the handler runs.
// - Interrupt stacking leaves out the upper index byte.
// - A subroutine call pushes a two-byte return address.
// - Stack pointer decrements on push and increments on pull.
// - ROM decodes into the upper user region and the vector region.
// - ROM contents cannot be viewed through the external port.
// - In wait mode the ROM stays in read mode, untouched.
// - Stop mode outside wait mode, with ROM in read mode, puts the ROM into standby.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module mmvd_memory_map #(
	parameter int ROM_FILL_CYCLES = mmvd_pkg::ROM_DEPTH
) (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// CPU bus
	input  wire logic [15:0] BUS_ADDR,
	input  wire logic [7:0]  BUS_WDATA,
	input  wire logic        BUS_WR,
	input  wire logic        BUS_RD,
	output logic      [7:0]  BUS_RDATA,
	// Stack requests
	input  wire logic        STK_INT_ENTRY,
	input  wire logic        STK_CALL,
	input  wire logic        STK_PULL,
	input  wire logic        STK_RSP,
	input  wire logic        STK_LOAD,
	input  wire logic [15:0] STK_LOAD_VAL,
	input  wire logic [15:0] CTX_PC,
	input  wire logic [7:0]  CTX_X,
	input  wire logic [7:0]  CTX_A,
	input  wire logic [7:0]  CTX_CCR,
	output logic      [15:0] STK_PTR,
	output logic      [7:0]  STK_PULL_DATA,
	output logic             STK_BUSY,
	output logic             STK_DONE,
	// Vector fetch
	input  wire logic [25:0] VEC_PEND,
	input  wire logic        VEC_REQ,
	output logic      [15:0] VEC_DATA,
	output logic      [4:0]  VEC_SRC,
	output logic             VEC_VALID,
	// ROM image load
	input  wire logic        ROM_LD_WR,
	input  wire logic [14:0] ROM_LD_ADDR,
	input  wire logic [7:0]  ROM_LD_DATA,
	output logic             ROM_READY,
	// External view port
	input  wire logic        EXT_RD,
	input  wire logic [15:0] EXT_ADDR,
	output logic      [7:0]  EXT_RDATA,
	// Power modes and watchdog
	input  wire logic        WAIT_MODE,
	input  wire logic        STOP_MODE,
	output logic             ROM_STANDBY,
	output logic             WDOG_CLR
);
	// ****************************************
	// Decode functions
	// ****************************************
	function automatic logic ram_hit(input logic [15:0] a);
		return ((a >= mmvd_pkg::RAM0_LO) && (a <= mmvd_pkg::RAM0_HI)) ||
		       ((a >= mmvd_pkg::RAM1_LO) && (a <= mmvd_pkg::RAM1_HI));
	endfunction
	function automatic logic [10:0] ram_index(input logic [15:0] a);
		logic [15:0] d;
		d = 16'h0000;
		if (a <= mmvd_pkg::RAM0_HI) begin
			d = a - mmvd_pkg::RAM0_LO;
		end else begin
			d = a - mmvd_pkg::RAM1_LO + {5'h00, mmvd_pkg::RAM1_BASE_IDX};
		end
		return d[10:0];
	endfunction
	function automatic logic rom_hit(input logic [15:0] a);
		return ((a >= mmvd_pkg::ROM_LO) && (a <= mmvd_pkg::ROM_HI)) ||
		       (a >= mmvd_pkg::VEC_LO);
	endfunction
	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] ram_mem [0:mmvd_pkg::RAM_BYTES-1];
	logic [7:0] rom_mem [0:mmvd_pkg::ROM_DEPTH-1];
	// ****************************************
	// State
	// ****************************************
	mmvd_pkg::mmvd_state_type state_ff;
	mmvd_pkg::mmvd_state_type nxt_state;
	logic [14:0] fill_cnt_ff;
	logic [39:0] ctx_ff;
	logic [2:0]  push_cnt_ff;
	logic [15:0] vec_addr_ff;
	logic [7:0]  ee_nv_opt_ff;
	logic [7:0]  ee_ctrl_ff;
	logic [7:0]  bus_rdata_ff;
	logic [7:0]  pull_data_ff;
	logic [7:0]  ext_rdata_ff;
	logic [15:0] vec_data_ff;
	logic [4:0]  vec_src_ff;
	logic        vec_valid_ff;
	logic        stk_done_ff;
	logic        standby_ff;
	logic        wdog_clr_ff;
	logic        busy_ff;
	logic        ready_ff;
	// ****************************************
	// Stack pointer and priority
	// ****************************************
	logic [15:0] sp;
	logic        pushing;
	logic        prio_valid;
	logic [4:0]  prio_idx;
	logic [15:0] prio_addr;
	assign pushing = (state_ff == mmvd_pkg::ST_STACK);
	mmvd_stack_ptr u_sp (
		.clk      (CORE_CLK),
		.rst      (SYS_RST),
		.rsp      (STK_RSP),
		.load     (STK_LOAD),
		.load_val (STK_LOAD_VAL),
		.push     (pushing),
		.pull     (STK_PULL & ~pushing),
		.sp       (sp)
	);
	mmvd_vec_prio #(
		.N (mmvd_pkg::VEC_COUNT)
	) u_prio (
		.pend     (VEC_PEND),
		.valid    (prio_valid),
		.idx      (prio_idx),
		.vec_addr (prio_addr)
	);
	// ****************************************
	// Bus decode
	// ****************************************
	logic        bus_ram;
	logic        bus_rom;
	logic        bus_wdog;
	logic [7:0]  rom_bus_byte;
	logic [7:0]  bus_rmux;
	logic [15:0] sp_up;
	logic        ram_free;
	logic        rom_read_mode;
	assign bus_ram = ram_hit(BUS_ADDR);
	assign bus_rom = rom_hit(BUS_ADDR);
	assign bus_wdog = (BUS_ADDR == mmvd_pkg::WDOG_CTRL_ADDR);
	assign rom_bus_byte = rom_mem[BUS_ADDR[14:0]];
	assign sp_up = sp + 16'h0001;
	assign ram_free = ~pushing;
	assign rom_read_mode = (state_ff != mmvd_pkg::ST_INIT) & ~ROM_LD_WR;
	always_comb begin
		bus_rmux = mmvd_pkg::RSV_RDATA;
		if (bus_ram) begin
			bus_rmux = ram_mem[ram_index(BUS_ADDR)];
		end else if (bus_wdog) begin
			bus_rmux = rom_bus_byte;
		end else if (bus_rom) begin
			bus_rmux = rom_bus_byte;
		end else if (BUS_ADDR == mmvd_pkg::EE_NV_OPT_ADDR) begin
			bus_rmux = ee_nv_opt_ff;
		end else if (BUS_ADDR == mmvd_pkg::EE_CTRL_ADDR) begin
			bus_rmux = ee_ctrl_ff & mmvd_pkg::EE_CTRL_MASK;
		end else if (BUS_ADDR == mmvd_pkg::EE_SHADOW_ADDR) begin
			bus_rmux = ee_nv_opt_ff;
		end
	end
	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			mmvd_pkg::ST_INIT: begin
				if (fill_cnt_ff == 15'(ROM_FILL_CYCLES - 1)) begin
					nxt_state = mmvd_pkg::ST_IDLE;
				end
			end
			mmvd_pkg::ST_IDLE: begin
				if (STK_INT_ENTRY || STK_CALL) begin
					nxt_state = mmvd_pkg::ST_STACK;
				end else if (VEC_REQ && prio_valid) begin
					nxt_state = mmvd_pkg::ST_VEC_HI;
				end
			end
			mmvd_pkg::ST_STACK: begin
				if (push_cnt_ff == 3'h1) begin
					nxt_state = mmvd_pkg::ST_IDLE;
				end
			end
			mmvd_pkg::ST_VEC_HI: begin
				nxt_state = mmvd_pkg::ST_VEC_LO;
			end
			mmvd_pkg::ST_VEC_LO: begin
				nxt_state = mmvd_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = mmvd_pkg::ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_ff <= mmvd_pkg::ST_INIT;
			fill_cnt_ff <= 15'h0000;
		end else begin
			state_ff <= nxt_state;
			fill_cnt_ff <= fill_cnt_ff + 15'h0001;
		end
	end
	// Context shifts out low byte first
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctx_ff <= 40'h0000000000;
			push_cnt_ff <= 3'h0;
		end else if ((state_ff == mmvd_pkg::ST_IDLE) && STK_INT_ENTRY) begin
			ctx_ff <= {CTX_CCR, CTX_A, CTX_X, CTX_PC[15:8], CTX_PC[7:0]};
			push_cnt_ff <= mmvd_pkg::INT_STACK_BYTES;
		end else if ((state_ff == mmvd_pkg::ST_IDLE) && STK_CALL) begin
			ctx_ff <= {24'h000000, CTX_PC[15:8], CTX_PC[7:0]};
			push_cnt_ff <= mmvd_pkg::CALL_STACK_BYTES;
		end else if (pushing) begin
			ctx_ff <= {8'h00, ctx_ff[39:8]};
			push_cnt_ff <= push_cnt_ff - 3'h1;
		end
	end
	// ****************************************
	// Memory writes
	// ****************************************
	always_ff @(posedge CORE_CLK) begin
		if (pushing && ram_hit(sp)) begin
			ram_mem[ram_index(sp)] <= ctx_ff[7:0];
		end else if (ram_free && BUS_WR && bus_ram) begin
			ram_mem[ram_index(BUS_ADDR)] <= BUS_WDATA;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (state_ff == mmvd_pkg::ST_INIT) begin
			rom_mem[fill_cnt_ff] <= mmvd_pkg::SWI_OPCODE;
		end else if (ROM_LD_WR) begin
			rom_mem[ROM_LD_ADDR] <= ROM_LD_DATA;
		end
	end
	// ****************************************
	// Registers and read paths
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ee_nv_opt_ff <= mmvd_pkg::EE_NV_OPT_RESET;
			ee_ctrl_ff <= mmvd_pkg::EE_CTRL_RESET;
			wdog_clr_ff <= 1'b0;
		end else begin
			if (BUS_WR && (BUS_ADDR == mmvd_pkg::EE_NV_OPT_ADDR)) begin
				ee_nv_opt_ff <= BUS_WDATA;
			end
			if (BUS_WR && (BUS_ADDR == mmvd_pkg::EE_CTRL_ADDR)) begin
				ee_ctrl_ff <= BUS_WDATA & mmvd_pkg::EE_CTRL_MASK;
			end
			wdog_clr_ff <= BUS_WR & bus_wdog;
		end
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			bus_rdata_ff <= 8'h00;
			pull_data_ff <= 8'h00;
			ext_rdata_ff <= 8'h00;
		end else begin
			if (BUS_RD) begin
				bus_rdata_ff <= bus_rmux;
			end
			if (STK_PULL && ~pushing) begin
				pull_data_ff <= ram_hit(sp_up) ? ram_mem[ram_index(sp_up)] : 8'h00;
			end
			if (EXT_RD) begin
				ext_rdata_ff <= rom_hit(EXT_ADDR) ? 8'h00 :
				                ram_hit(EXT_ADDR) ? ram_mem[ram_index(EXT_ADDR)] : 8'h00;
			end
		end
	end
	// ****************************************
	// Vector fetch
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			vec_addr_ff <= mmvd_pkg::VEC_HI;
			vec_src_ff <= 5'h00;
			vec_data_ff <= 16'h0000;
			vec_valid_ff <= 1'b0;
		end else begin
			vec_valid_ff <= (state_ff == mmvd_pkg::ST_VEC_LO);
			if ((state_ff == mmvd_pkg::ST_IDLE) && (nxt_state == mmvd_pkg::ST_VEC_HI)) begin
				vec_addr_ff <= prio_addr;
				vec_src_ff <= prio_idx;
			end
			if (state_ff == mmvd_pkg::ST_VEC_HI) begin
				vec_data_ff[15:8] <= rom_mem[vec_addr_ff[14:0]];
			end
			if (state_ff == mmvd_pkg::ST_VEC_LO) begin
				vec_data_ff[7:0] <= rom_mem[vec_addr_ff[14:0] + 15'h0001];
			end
		end
	end
	// ****************************************
	// Status and power
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stk_done_ff <= 1'b0;
			standby_ff <= 1'b0;
			busy_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			stk_done_ff <= pushing & (push_cnt_ff == 3'h1);
			busy_ff <= (nxt_state == mmvd_pkg::ST_STACK);
			ready_ff <= (nxt_state != mmvd_pkg::ST_INIT);
			standby_ff <= STOP_MODE & ~WAIT_MODE & rom_read_mode;
		end
	end
	assign BUS_RDATA = bus_rdata_ff;
	assign STK_PTR = sp;
	assign STK_PULL_DATA = pull_data_ff;
	assign STK_BUSY = busy_ff;
	assign STK_DONE = stk_done_ff;
	assign VEC_DATA = vec_data_ff;
	assign VEC_SRC = vec_src_ff;
	assign VEC_VALID = vec_valid_ff;
	assign ROM_READY = ready_ff;
	assign EXT_RDATA = ext_rdata_ff;
	assign ROM_STANDBY = standby_ff;
	assign WDOG_CLR = wdog_clr_ff;
endmodule

/* File: rtl/mmvd_pkg.sv */
// Constants, states and address map of the upper memory map decoder.
// Assumes an 8-bit CPU core with a 16-bit address bus on one clock.
package mmvd_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int RAM_IDX_W = 11;
	localparam int VEC_IDX_W = 5;

	// ****************************************
	// RAM regions
	// ****************************************
	localparam logic [15:0] RAM0_LO = 16'h0050;
	localparam logic [15:0] RAM0_HI = 16'h044f;
	localparam logic [15:0] RAM1_LO = 16'h0a00;
	localparam logic [15:0] RAM1_HI = 16'h0dff;
	localparam int RAM_BYTES = 2048;
	localparam int PAGE0_RAM_BYTES = 176;
	localparam logic [10:0] RAM1_BASE_IDX = 11'h400;

	// ****************************************
	// ROM and vector regions
	// ****************************************
	localparam logic [15:0] ROM_LO = 16'h8000;
	localparam logic [15:0] ROM_HI = 16'hfdff;
	localparam logic [15:0] VEC_LO = 16'hffcc;
	localparam logic [15:0] VEC_HI = 16'hffff;
	localparam int VEC_COUNT = 26;
	localparam int ROM_DEPTH = 32768;
	localparam logic [7:0] SWI_OPCODE = 8'h83;

	// ****************************************
	// Stack
	// ****************************************
	localparam logic [15:0] SP_RESET = 16'h00ff;
	localparam logic [2:0] INT_STACK_BYTES = 3'h5;
	localparam logic [2:0] CALL_STACK_BYTES = 3'h2;

	// ****************************************
	// Registers
	// ****************************************
	localparam logic [15:0] EE_NV_OPT_ADDR = 16'hfe1c;
	localparam logic [15:0] EE_CTRL_ADDR = 16'hfe1d;
	localparam logic [15:0] EE_RSV_ADDR = 16'hfe1e;
	localparam logic [15:0] EE_SHADOW_ADDR = 16'hfe1f;
	localparam logic [15:0] RSV0_ADDR = 16'hff80;
	localparam logic [15:0] RSV1_ADDR = 16'hff81;
	localparam logic [15:0] WDOG_CTRL_ADDR = 16'hffff;
	localparam logic [7:0] EE_NV_OPT_RESET = 8'h00;
	localparam logic [7:0] EE_CTRL_RESET = 8'h00;
	localparam logic [7:0] EE_CTRL_MASK = 8'hbd;
	localparam logic [7:0] RSV_RDATA = 8'h00;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		ST_INIT   = 3'b000,
		ST_IDLE   = 3'b001,
		ST_STACK  = 3'b010,
		ST_VEC_HI = 3'b011,
		ST_VEC_LO = 3'b100
	} mmvd_state_type;

endpackage

/* File: rtl/mmvd_stack_ptr.sv */
// Sixteen-bit stack pointer with reset value, reload, push and pull steps.
// Assumes push, pull and load requests are never active together.
`timescale 1ns/1ps
module mmvd_stack_ptr (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Requests
	input  wire logic        rsp,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	input  wire logic        push,
	input  wire logic        pull,
	// State
	output logic      [15:0] sp
);

	logic [15:0] sp_ff;
	logic [15:0] nxt_sp;

	assign nxt_sp = rsp  ? mmvd_pkg::SP_RESET :
	                load ? load_val :
	                push ? sp_ff - 16'h0001 :
	                pull ? sp_ff + 16'h0001 :
	                sp_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sp_ff <= mmvd_pkg::SP_RESET;
		end else begin
			sp_ff <= nxt_sp;
		end
	end

	assign sp = sp_ff;

endmodule

/* File: rtl/mmvd_vec_prio.sv */
// Fixed-priority selection among pending vector sources.
// Bit 0 is the lowest slot, the top bit is reset; pure combinational logic.
`timescale 1ns/1ps
module mmvd_vec_prio #(
	parameter int N = mmvd_pkg::VEC_COUNT
) (
	// Pending sources
	input  wire logic [N-1:0] pend,
	// Selection
	output logic              valid,
	output logic [4:0]        idx,
	output logic [15:0]       vec_addr
);

	function automatic logic [4:0] top_index(input logic [N-1:0] p);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < N; i++) begin
			if (p[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	assign valid = |pend;
	assign idx = top_index(pend);
	assign vec_addr = mmvd_pkg::VEC_LO + {10'h000, idx, 1'b0};

endmodule

/* File: test/mmvd_cpu_model.sv */
// Behavioural CPU core issuing byte reads and writes on the decoder bus.
// Assumes the bench calls one task at a time after reset release.
`timescale 1ns/1ps
module mmvd_cpu_model (
	// Clock
	input  wire logic        CORE_CLK,
	// Bus toward the decoder
	output logic      [15:0] BUS_ADDR,
	output logic      [7:0]  BUS_WDATA,
	output logic             BUS_WR,
	output logic             BUS_RD,
	input  wire logic [7:0]  BUS_RDATA
);
	initial begin
		{BUS_ADDR, BUS_WDATA, BUS_WR, BUS_RD} = '0;
	end

	// Idle bus shows inverted values so stale data never matches
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge CORE_CLK);
		BUS_ADDR  <= a;
		BUS_WDATA <= v;
		BUS_WR    <= 1'b1;
		@(posedge CORE_CLK);
		BUS_WR    <= 1'b0;
		BUS_ADDR  <= ~a;
		BUS_WDATA <= ~v;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge CORE_CLK);
		BUS_ADDR <= a;
		BUS_RD   <= 1'b1;
		@(posedge CORE_CLK);
		BUS_RD   <= 1'b0;
		BUS_ADDR <= ~a;
		#1;
		v = BUS_RDATA;
	endtask
endmodule

/* File: test/mmvd_map_properties.sv */
// Port-level timing checks of the upper memory map decoder.
// Assumes binding to mmvd_memory_map: one clock, async active-high reset.
`timescale 1ns/1ps
module mmvd_map_properties (
	// Clock and reset
	input wire logic        CORE_CLK,
	input wire logic        SYS_RST,
	// Bus and stack
	input wire logic [15:0] BUS_ADDR,
	input wire logic        BUS_WR,
	input wire logic        STK_INT_ENTRY,
	input wire logic        STK_CALL,
	input wire logic        STK_RSP,
	input wire logic [15:0] STK_PTR,
	input wire logic        STK_BUSY,
	input wire logic        STK_DONE,
	// Vectors, port, modes
	input wire logic [25:0] VEC_PEND,
	input wire logic        VEC_REQ,
	input wire logic [4:0]  VEC_SRC,
	input wire logic        VEC_VALID,
	input wire logic        EXT_RD,
	input wire logic [15:0] EXT_ADDR,
	input wire logic [7:0]  EXT_RDATA,
	input wire logic        WAIT_MODE,
	input wire logic        STOP_MODE,
	input wire logic        ROM_STANDBY,
	input wire logic        WDOG_CLR,
	input wire logic        ROM_READY,
	input wire logic        ROM_LD_WR
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	a_wdog_clear: assert property (BUS_WR && BUS_ADDR == 16'hffff |=> WDOG_CLR)
		else $error("watchdog clear missing");
	a_int_stack: assert property (STK_INT_ENTRY && !STK_BUSY ##1 STK_BUSY
		|-> STK_BUSY[*5] ##1 (!STK_BUSY && STK_DONE)) else $error("int stacking length");
	a_call_stack: assert property (STK_CALL && !STK_INT_ENTRY && !STK_BUSY ##1 STK_BUSY
		|-> STK_BUSY[*2] ##1 (!STK_BUSY && STK_DONE)) else $error("call stacking length");
	a_push_step: assert property (STK_BUSY |=> STK_PTR == $past(STK_PTR) - 16'h1)
		else $error("push step wrong");
	a_rsp_value: assert property (STK_RSP |=> STK_PTR == 16'h00ff)
		else $error("stack reload wrong");
	a_vec_latency: assert property (VEC_REQ && VEC_PEND != 26'h0 && ROM_READY && !STK_BUSY
		&& !STK_INT_ENTRY && !STK_CALL |-> ##3 VEC_VALID) else $error("vector late");
	a_vec_prio: assert property (VEC_VALID |-> (VEC_PEND >> VEC_SRC) == 26'h1)
		else $error("vector priority wrong");
	a_stop_standby: assert property (STOP_MODE && !WAIT_MODE && ROM_READY && !ROM_LD_WR
		|=> ROM_STANDBY) else $error("standby missing");
	a_wait_awake: assert property (WAIT_MODE |=> !ROM_STANDBY)
		else $error("standby in wait");
	a_ext_secure: assert property (EXT_RD && EXT_ADDR[15] |=> EXT_RDATA == 8'h00)
		else $error("rom visible outside");

	c_int: cover property (STK_DONE);
	c_vec: cover property (VEC_VALID && VEC_SRC == 5'd25);
	c_wdog: cover property (WDOG_CLR);
endmodule

bind mmvd_memory_map mmvd_map_properties u_props (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR),
	.STK_INT_ENTRY(STK_INT_ENTRY), .STK_CALL(STK_CALL), .STK_RSP(STK_RSP),
	.STK_PTR(STK_PTR), .STK_BUSY(STK_BUSY), .STK_DONE(STK_DONE), .VEC_PEND(VEC_PEND),
	.VEC_REQ(VEC_REQ), .VEC_SRC(VEC_SRC), .VEC_VALID(VEC_VALID), .EXT_RD(EXT_RD),
	.EXT_ADDR(EXT_ADDR), .EXT_RDATA(EXT_RDATA), .WAIT_MODE(WAIT_MODE),
	.STOP_MODE(STOP_MODE), .ROM_STANDBY(ROM_STANDBY), .WDOG_CLR(WDOG_CLR),
	.ROM_READY(ROM_READY), .ROM_LD_WR(ROM_LD_WR)
);

/* File: test/tb_memory_map_vector_decode.sv */
// Self-checking bench of the upper memory map decoder.
// Assumes mmvd_pkg, the design and the CPU model are compiled first.
`timescale 1ns/1ps
module tb_memory_map_vector_decode;
	logic        CORE_CLK, SYS_RST, BUS_WR, BUS_RD, STK_INT_ENTRY, STK_CALL, STK_PULL;
	logic        STK_RSP, STK_LOAD, STK_BUSY, STK_DONE, VEC_REQ, VEC_VALID, ROM_LD_WR;
	logic        ROM_READY, EXT_RD, WAIT_MODE, STOP_MODE, ROM_STANDBY, WDOG_CLR;
	logic [15:0] BUS_ADDR, STK_LOAD_VAL, CTX_PC, STK_PTR, VEC_DATA, EXT_ADDR;
	logic [7:0]  BUS_WDATA, BUS_RDATA, CTX_X, CTX_A, CTX_CCR, STK_PULL_DATA;
	logic [7:0]  ROM_LD_DATA, EXT_RDATA, d;
	logic [25:0] VEC_PEND;
	logic [4:0]  VEC_SRC;
	logic [14:0] ROM_LD_ADDR;
	int          n_fail = 0;
	int          n_checks = 0;
	// Address, write data, expected read
	logic [31:0] tbl [12] = '{32'h0050a1a1, 32'h044fb2b2, 32'h0a00c3c3, 32'h0dffd4d4,
		32'h0450ff00, 32'hfe1eff00, 32'hff80ff00, 32'hff81ff00, 32'hfe1c5a5a,
		32'hfe1fff5a, 32'hfe1dffbd, 32'h80010083};
	logic [23:0] rl [4] = '{24'h7ffe12, 24'h7fff34, 24'h7fccab, 24'h7fcdcd};
	logic [7:0]  frame [5] = '{8'h78, 8'h56, 8'h11, 8'h22, 8'h33};

	mmvd_memory_map #(.ROM_FILL_CYCLES(64)) u_dut (
		.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
		.BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA),
		.STK_INT_ENTRY(STK_INT_ENTRY), .STK_CALL(STK_CALL), .STK_PULL(STK_PULL),
		.STK_RSP(STK_RSP), .STK_LOAD(STK_LOAD), .STK_LOAD_VAL(STK_LOAD_VAL),
		.CTX_PC(CTX_PC), .CTX_X(CTX_X), .CTX_A(CTX_A), .CTX_CCR(CTX_CCR),
		.STK_PTR(STK_PTR), .STK_PULL_DATA(STK_PULL_DATA), .STK_BUSY(STK_BUSY),
		.STK_DONE(STK_DONE), .VEC_PEND(VEC_PEND), .VEC_REQ(VEC_REQ), .VEC_DATA(VEC_DATA),
		.VEC_SRC(VEC_SRC), .VEC_VALID(VEC_VALID), .ROM_LD_WR(ROM_LD_WR),
		.ROM_LD_ADDR(ROM_LD_ADDR), .ROM_LD_DATA(ROM_LD_DATA), .ROM_READY(ROM_READY),
		.EXT_RD(EXT_RD), .EXT_ADDR(EXT_ADDR), .EXT_RDATA(EXT_RDATA),
		.WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE), .ROM_STANDBY(ROM_STANDBY),
		.WDOG_CLR(WDOG_CLR)
	);

	mmvd_cpu_model u_cpu (
		.CORE_CLK(CORE_CLK), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
		.BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA)
	);

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic romld(input logic [14:0] a, input logic [7:0] v);
		@(posedge CORE_CLK);
		ROM_LD_WR   <= 1'b1;
		ROM_LD_ADDR <= a;
		ROM_LD_DATA <= v;
		@(posedge CORE_CLK);
		ROM_LD_WR   <= 1'b0;
	endtask

	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	initial begin
		#50000;
		n_fail++;
		print_verdict();
	end

	initial begin
		SYS_RST = 1'b1;
		{STK_INT_ENTRY, STK_CALL, STK_PULL, STK_RSP, STK_LOAD, VEC_REQ} = '0;
		{ROM_LD_WR, EXT_RD, WAIT_MODE, STOP_MODE} = '0;
		{STK_LOAD_VAL, CTX_PC, CTX_X, CTX_A, CTX_CCR, VEC_PEND} = '0;
		{ROM_LD_ADDR, ROM_LD_DATA, EXT_ADDR} = '0;
		repeat (11) @(posedge CORE_CLK);
		#1;
		chk("sp reset", 16'h00ff, STK_PTR);
		@(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		for (int i = 0; i < 200 && ROM_READY !== 1'b1; i++) begin
			@(posedge CORE_CLK);
			#1;
		end
		chk("rom ready", 1, ROM_READY);
		u_cpu.rd(16'hfe1c, d);
		chk("nv reset", 8'h00, d);
		u_cpu.rd(16'hfe1d, d);
		chk("ctrl reset", 8'h00, d);
		for (int i = 0; i < 12; i++) begin
			u_cpu.wr(tbl[i][31:16], tbl[i][15:8]);
			u_cpu.rd(tbl[i][31:16], d);
			chk("map rw", tbl[i][7:0], d);
		end
		u_cpu.rd(16'h803f, d);
		chk("rom fill", 8'h83, d);
		@(posedge CORE_CLK);
		EXT_RD   <= 1'b1;
		EXT_ADDR <= 16'h803f;
		@(posedge CORE_CLK);
		EXT_RD   <= 1'b0;
		#1;
		chk("ext rom", 8'h00, EXT_RDATA);
		for (int i = 0; i < 4; i++)
			romld(rl[i][22:8], rl[i][7:0]);
		u_cpu.wr(16'hffff, 8'h55);
		#1;
		chk("wdog clr", 1, WDOG_CLR);
		u_cpu.rd(16'hffff, d);
		chk("reset vec low", 8'h34, d);
		for (int i = 0; i < 2; i++) begin
			@(posedge CORE_CLK);
			VEC_PEND <= i ? 26'h1 : 26'h2000001;
			VEC_REQ  <= 1'b1;
			@(posedge CORE_CLK);
			VEC_REQ  <= 1'b0;
			repeat (2) @(posedge CORE_CLK);
			#1;
			chk("vec valid", 1, VEC_VALID);
			chk("vec data", i ? 16'habcd : 16'h1234, VEC_DATA);
			chk("vec src", i ? 5'd0 : 5'd25, VEC_SRC);
		end
		@(posedge CORE_CLK);
		{CTX_PC, CTX_X, CTX_A, CTX_CCR} <= 40'h5678112233;
		STK_INT_ENTRY <= 1'b1;
		@(posedge CORE_CLK);
		STK_INT_ENTRY <= 1'b0;
		repeat (5) @(posedge CORE_CLK);
		#1;
		chk("int done", 1, STK_DONE);
		chk("int sp", 16'h00fa, STK_PTR);
		for (int i = 0; i < 5; i++) begin
			u_cpu.rd(16'h00ff - 16'(i), d);
			chk("int frame", frame[i], d);
		end
		@(posedge CORE_CLK);
		STK_PULL <= 1'b1;
		@(posedge CORE_CLK);
		STK_PULL <= 1'b0;
		@(posedge CORE_CLK);
		#1;
		chk("pull sp", 16'h00fb, STK_PTR);
		chk("pull data", 8'h33, STK_PULL_DATA);
		@(posedge CORE_CLK);
		CTX_PC   <= 16'h9abc;
		STK_CALL <= 1'b1;
		@(posedge CORE_CLK);
		STK_CALL <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		#1;
		chk("call sp", 16'h00f9, STK_PTR);
		u_cpu.rd(16'h00fb, d);
		chk("call pcl", 8'hbc, d);
		u_cpu.rd(16'h00fa, d);
		chk("call pch", 8'h9a, d);
		@(posedge CORE_CLK);
		STK_LOAD     <= 1'b1;
		STK_LOAD_VAL <= 16'h0a10;
		@(posedge CORE_CLK);
		STK_LOAD <= 1'b0;
		STK_RSP  <= 1'b1;
		#1;
		chk("sp load", 16'h0a10, STK_PTR);
		@(posedge CORE_CLK);
		STK_RSP <= 1'b0;
		#1;
		chk("sp reload", 16'h00ff, STK_PTR);
		@(posedge CORE_CLK);
		STOP_MODE <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		#1;
		chk("stop standby", 1, ROM_STANDBY);
		@(posedge CORE_CLK);
		WAIT_MODE <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		#1;
		chk("wait awake", 0, ROM_STANDBY);
		print_verdict();
	end
endmodule
